// ===== logic/pes_pkg.sv
// Constants, register map and field layout of the PHY extended status and control bank
// What this block does
// - Speed reads 10 for 1000 Mbps; duplex 1 full, 0 half; valid once resolved.
// - Resolved flag is set when auto-negotiation completed or disabled, else 0.
// - Page received bit latches high on a page and clears when read.
// - Crossover bit is set when pairs A/B and C/D are swapped.
// - Two read-only bits show transmit and receive pause capability of the host MAC.
// - Polarity bit is set when any of the four pairs is reversed.
// - Jabber bit reads 1 while jabber is detected, 0 otherwise.
// - No idles within 1 ms drops lock, brings link down, sets idle-loss bit.
// - Serial-side auto-negotiation enable, reset 1, applied only at a software reset.
// - Receive error counter is 16 bits and saturates at all ones.
`default_nettype none
package pes_pkg;
   // Bus geometry
   localparam int          WB_AW            = 8;
   localparam int          WB_DW            = 32;
   localparam int          REG_W            = 16;
   // Register indices, byte address is four times the index
   localparam logic [5:0]  IDX_STAT1        = 6'h11;
   localparam logic [5:0]  IDX_CTRL2        = 6'h14;
   localparam logic [5:0]  IDX_RXERR        = 6'h15;
   localparam logic [5:0]  IDX_IRQ_STAT     = 6'h18;
   localparam logic [5:0]  IDX_IRQ_MASK     = 6'h19;
   localparam logic [5:0]  IDX_SOFT_RST     = 6'h1A;
   // Extended status one fields
   localparam int          ST_SPEED_HI      = 15;
   localparam int          ST_SPEED_LO      = 14;
   localparam int          ST_DUPLEX        = 13;
   localparam int          ST_PAGE          = 12;
   localparam int          ST_RESOLVED      = 11;
   localparam int          ST_LINK          = 10;
   localparam int          ST_XOVER         = 6;
   localparam int          ST_TX_PAUSE      = 3;
   localparam int          ST_RX_PAUSE      = 2;
   localparam int          ST_POLARITY      = 1;
   localparam int          ST_JABBER        = 0;
   localparam logic [1:0]  SPEED_1000       = 2'h2;
   // Extended control two fields
   localparam int          CT_IDLE_LOSS     = 15;
   localparam int          CT_SER_AN        = 3;
   localparam logic [15:0] CTRL2_RST        = 16'h0C68;
   localparam logic [15:0] CTRL2_WR_MASK    = 16'h7FFF;
   // Receive error counter
   localparam logic [15:0] RXERR_RST        = 16'h0000;
   localparam logic [15:0] RXERR_MAX        = 16'hFFFF;
   // Interrupt status and mask layout
   localparam int          IRQ_W            = 4;
   localparam int          IRQ_PAGE         = 0;
   localparam int          IRQ_IDLE_LOSS    = 1;
   localparam int          IRQ_JABBER       = 2;
   localparam int          IRQ_ERR_SAT      = 3;
   localparam logic [3:0]  IRQ_MASK_RST     = 4'h0;
   // Software reset register
   localparam int          SR_GO            = 0;
   // Idle watchdog timing
   localparam int          IDLE_TIMEOUT_MS  = 1;
   localparam int          CLK_MHZ          = 250;
   localparam int          IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_MS * CLK_MHZ * 1000;
   // Idle watchdog states
   typedef enum logic [1:0] {
      PES_WD_OFF    = 2'b00,
      PES_WD_LOCKED = 2'b01,
      PES_WD_LOST   = 2'b10
   } pes_wd_e;
endpackage
`default_nettype wire

// ===== logic/pes_idle_wd.sv
// Idle pattern watchdog that guards the link lock
`timescale 1ns/1ps
`default_nettype none
module pes_idle_wd #(
   parameter int TIMEOUT_CYC = pes_pkg::IDLE_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Link activity
   input  wire logic active_i,
   input  wire logic idle_i,
   // Lock state
   output logic      lock_o,
   output logic      lost_o,
   output logic      lost_pulse_o
);
   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

   pes_pkg::pes_wd_e state_q;
   logic [CW-1:0]    cnt_q;

   ////////////////////////////////////////////////////////////////////////////
   // Lock state machine, lock falls after a full timeout without idles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= pes_pkg::PES_WD_OFF;
      end else begin
         case (state_q)
            pes_pkg::PES_WD_OFF: begin
               if (active_i) begin
                  state_q <= pes_pkg::PES_WD_LOCKED;
               end
            end
            pes_pkg::PES_WD_LOCKED: begin
               if (!active_i) begin
                  state_q <= pes_pkg::PES_WD_OFF;
               end else if (!idle_i && cnt_q == LAST) begin
                  state_q <= pes_pkg::PES_WD_LOST;
               end
            end
            pes_pkg::PES_WD_LOST: begin
               if (!active_i) begin
                  state_q <= pes_pkg::PES_WD_OFF;
               end else if (idle_i) begin
                  state_q <= pes_pkg::PES_WD_LOCKED;
               end
            end
            default: state_q <= pes_pkg::PES_WD_OFF;
         endcase
      end
   end

   // Cycles since the last idle pattern
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (state_q != pes_pkg::PES_WD_LOCKED || idle_i) begin
         cnt_q <= '0;
      end else if (cnt_q != LAST) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Lock outputs
   assign lock_o       = (state_q == pes_pkg::PES_WD_LOCKED);
   assign lost_o       = (state_q == pes_pkg::PES_WD_LOST);
   assign lost_pulse_o = lock_o && active_i && !idle_i && cnt_q == LAST;
endmodule
`default_nettype wire

// ===== logic/pes_regs.sv
// Extended status, control and receive error registers on a classic Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module pes_regs #(
   parameter int IDLE_TIMEOUT_CYC = pes_pkg::IDLE_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Wishbone slave
   input  wire logic                     cyc_i,
   input  wire logic                     stb_i,
   input  wire logic                     we_i,
   input  wire logic [pes_pkg::WB_AW-1:0] adr_i,
   input  wire logic [3:0]               sel_i,
   input  wire logic [pes_pkg::WB_DW-1:0] dat_i,
   output logic      [pes_pkg::WB_DW-1:0] dat_o,
   output logic                          ack_o,
   // Twisted-pair side status
   input  wire logic [1:0]               speed_i,
   input  wire logic                     full_duplex_i,
   input  wire logic                     tp_an_enable_i,
   input  wire logic                     tp_an_complete_i,
   input  wire logic                     page_rx_i,
   input  wire logic                     link_up_i,
   input  wire logic                     crossover_i,
   input  wire logic [3:0]               pair_reversed_i,
   input  wire logic                     jabber_i,
   input  wire logic                     rx_error_i,
   input  wire logic                     idle_seen_i,
   // Serial side status
   input  wire logic                     mac_tx_pause_i,
   input  wire logic                     mac_rx_pause_i,
   // Control outputs
   output logic                          serdes_an_en_o,
   output logic                          link_lock_o,
   output logic                          soft_rst_o,
   // Interrupt
   output logic                          irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Merge write data into a register through the byte lanes
   function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = new_v[7:0];
      end
      if (sel[1]) begin
         r[15:8] = new_v[15:8];
      end
      return r;
   endfunction

   // Register declarations
   logic                 ack_q;
   logic [31:0]          rdata_q;
   logic [15:0]          ctrl_q;
   logic                 ser_an_q;
   logic                 page_q;
   logic [15:0]          err_q;
   logic [3:0]           irq_stat_q;
   logic [3:0]           irq_mask_q;
   logic                 srst_q;
   logic                 jab_q;
   logic                 sat_hit;
   logic [1:0]           speed_q;
   logic                 dup_q;
   logic                 res_q;
   logic                 xover_q;
   logic                 txp_q;
   logic                 rxp_q;
   logic                 pol_q;
   logic                 link_q;
   logic                 lock;
   logic                 lost;
   logic                 lost_pulse;
   logic                 req;
   logic                 wr;
   logic                 rd;
   logic [5:0]           idx;
   logic [15:0]          wdat;
   logic [15:0]          stat1;
   logic [15:0]          ctrl_rd;
   logic [3:0]           irq_set;
   logic                 rd_stat1;
   logic                 rd_err;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode, a request is taken in the cycle before its ack
   assign req      = cyc_i && stb_i && !ack_q;
   assign wr       = req && we_i;
   assign rd       = req && !we_i;
   assign idx      = adr_i[7:2];
   assign wdat     = dat_i[15:0];
   assign rd_stat1 = rd && idx == pes_pkg::IDX_STAT1;
   assign rd_err   = rd && idx == pes_pkg::IDX_RXERR;

   // Ack one cycle after the request, dropped in the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end
   assign ack_o = ack_q;

   ////////////////////////////////////////////////////////////////////////////
   // Idle watchdog for link lock
   pes_idle_wd #(
      .TIMEOUT_CYC (IDLE_TIMEOUT_CYC)
   ) u_idle_wd (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .active_i     (link_up_i),
      .idle_i       (idle_seen_i),
      .lock_o       (lock),
      .lost_o       (lost),
      .lost_pulse_o (lost_pulse)
   );
   assign link_lock_o = lock;

   ////////////////////////////////////////////////////////////////////////////
   // Sampled status of the twisted-pair and serial sides
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         speed_q <= 2'h0;
         dup_q   <= 1'b0;
         res_q   <= 1'b0;
         xover_q <= 1'b0;
         txp_q   <= 1'b0;
         rxp_q   <= 1'b0;
         pol_q   <= 1'b0;
         jab_q   <= 1'b0;
         link_q  <= 1'b0;
      end else begin
         speed_q <= speed_i;
         dup_q   <= full_duplex_i;
         res_q   <= tp_an_enable_i ? tp_an_complete_i : 1'b1;
         xover_q <= crossover_i;
         txp_q   <= mac_tx_pause_i;
         rxp_q   <= mac_rx_pause_i;
         pol_q   <= |pair_reversed_i;
         jab_q   <= jabber_i;
         link_q  <= link_up_i && lock;
      end
   end

   // Page received latches high, cleared by a read, a new page wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         page_q <= 1'b0;
      end else if (page_rx_i) begin
         page_q <= 1'b1;
      end else if (rd_stat1 || srst_q) begin
         page_q <= 1'b0;
      end
   end

   // Extended status one word
   always_comb begin
      stat1                                         = 16'h0000;
      stat1[pes_pkg::ST_SPEED_HI:pes_pkg::ST_SPEED_LO] = speed_q;
      stat1[pes_pkg::ST_DUPLEX]                     = dup_q;
      stat1[pes_pkg::ST_PAGE]                       = page_q;
      stat1[pes_pkg::ST_RESOLVED]                   = res_q;
      stat1[pes_pkg::ST_LINK]                       = link_q;
      stat1[pes_pkg::ST_XOVER]                      = xover_q;
      stat1[pes_pkg::ST_TX_PAUSE]                   = txp_q;
      stat1[pes_pkg::ST_RX_PAUSE]                   = rxp_q;
      stat1[pes_pkg::ST_POLARITY]                   = pol_q;
      stat1[pes_pkg::ST_JABBER]                     = jab_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Extended control two, unused bits are stored as written for the host
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= pes_pkg::CTRL2_RST;
      end else if (wr && idx == pes_pkg::IDX_CTRL2) begin
         ctrl_q <= lane_merge(ctrl_q, wdat, sel_i[1:0]) & pes_pkg::CTRL2_WR_MASK;
      end
   end

   // Serial auto-negotiation enable applied only at a software reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ser_an_q <= pes_pkg::CTRL2_RST[pes_pkg::CT_SER_AN];
      end else if (srst_q) begin
         ser_an_q <= ctrl_q[pes_pkg::CT_SER_AN];
      end
   end
   assign serdes_an_en_o = ser_an_q;

   // Control word as read, with the idle-loss flag on top
   always_comb begin
      ctrl_rd                       = ctrl_q;
      ctrl_rd[pes_pkg::CT_IDLE_LOSS] = lost;
   end

   // Software reset strobe, one cycle per write of a one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= wr && idx == pes_pkg::IDX_SOFT_RST && sel_i[0] && dat_i[pes_pkg::SR_GO];
      end
   end
   assign soft_rst_o = srst_q;

   ////////////////////////////////////////////////////////////////////////////
   // Receive error counter, saturating, cleared by a read, a new error wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_q <= pes_pkg::RXERR_RST;
      end else if (rd_err || srst_q) begin
         err_q <= rx_error_i ? 16'h0001 : pes_pkg::RXERR_RST;
      end else if (rx_error_i && err_q != pes_pkg::RXERR_MAX) begin
         err_q <= err_q + 16'h0001;
      end
   end

   // Counter reaches saturation in this cycle
   assign sat_hit = rx_error_i && !rd_err && !srst_q && err_q == 16'hFFFE;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events
   always_comb begin
      irq_set                         = 4'h0;
      irq_set[pes_pkg::IRQ_PAGE]      = page_rx_i;
      irq_set[pes_pkg::IRQ_IDLE_LOSS] = lost_pulse;
      irq_set[pes_pkg::IRQ_JABBER]    = jabber_i && !jab_q;
      irq_set[pes_pkg::IRQ_ERR_SAT]   = sat_hit;
   end

   // Sticky status, write one to clear, a new event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= 4'h0;
      end else if (wr && idx == pes_pkg::IDX_IRQ_STAT && sel_i[0]) begin
         irq_stat_q <= (irq_stat_q & ~dat_i[3:0]) | irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_q <= pes_pkg::IRQ_MASK_RST;
      end else if (wr && idx == pes_pkg::IDX_IRQ_MASK && sel_i[0]) begin
         irq_mask_q <= dat_i[3:0];
      end
   end
   assign irq_o = |(irq_stat_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd) begin
         case (idx)
            pes_pkg::IDX_STAT1:    rdata_q <= {16'h0000, stat1};
            pes_pkg::IDX_CTRL2:    rdata_q <= {16'h0000, ctrl_rd};
            pes_pkg::IDX_RXERR:    rdata_q <= {16'h0000, err_q};
            pes_pkg::IDX_IRQ_STAT: rdata_q <= {28'h000_0000, irq_stat_q};
            pes_pkg::IDX_IRQ_MASK: rdata_q <= {28'h000_0000, irq_mask_q};
            default:               rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign dat_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Bus answer
   ack_single_a: assert property (ack_o |=> !ack_o)
      else $error("ack held for more than one cycle");
   ack_follows_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered in one cycle");

   // Status bits
   speed_dup_a: assert property (##1 stat1[15:13] == $past({speed_i, full_duplex_i}))
      else $error("speed or duplex does not follow the resolved input");
   resolved_a: assert property (!tp_an_enable_i |=> stat1[pes_pkg::ST_RESOLVED])
      else $error("resolved flag low with auto-negotiation disabled");
   resolved_low_a: assert property (tp_an_enable_i && !tp_an_complete_i |=> !res_q)
      else $error("resolved flag set before completion");
   page_set_a: assert property (page_rx_i |=> page_q ##1 (page_q || $past(rd_stat1 || srst_q)))
      else $error("page received not latched");
   page_hold_a: assert property (page_q && !rd_stat1 && !srst_q |=> page_q)
      else $error("page received lost without a read");
   xover_a: assert property (##1 xover_q == $past(crossover_i))
      else $error("crossover bit wrong");
   pause_a: assert property (##1 {txp_q, rxp_q} == $past({mac_tx_pause_i, mac_rx_pause_i}))
      else $error("pause bits wrong");
   polarity_a: assert property (pair_reversed_i != 4'h0 |=> stat1[pes_pkg::ST_POLARITY])
      else $error("polarity bit not set");
   jabber_a: assert property (jabber_i [*2] |-> stat1[pes_pkg::ST_JABBER])
      else $error("jabber bit not set");
   idle_loss_a: assert property (lost_pulse |=> ctrl_rd[pes_pkg::CT_IDLE_LOSS] ##1 !link_q)
      else $error("idle loss not reported or link kept up");
   ser_an_a: assert property (!srst_q |=> $stable(serdes_an_en_o))
      else $error("serial auto-negotiation enable changed without soft reset");
   err_sat_a: assert property (err_q == pes_pkg::RXERR_MAX && !rd_err && !srst_q |=> err_q == pes_pkg::RXERR_MAX)
      else $error("error counter rolled over");
   err_inc_a: assert property (rx_error_i && !rd_err && !srst_q && err_q != 16'hFFFF |=> err_q == $past(err_q) + 16'h0001)
      else $error("error counter missed an error");
   err_clr_a: assert property (rd_err && !rx_error_i |=> err_q == 16'h0000)
      else $error("error counter not cleared by read");
   irq_level_a: assert property (irq_stat_q[pes_pkg::IRQ_PAGE] && irq_mask_q[pes_pkg::IRQ_PAGE] |-> irq_o)
      else $error("unmasked event not on interrupt");

   // Events, lanes, strobes and lock
   page_irq_a: assert property (page_rx_i |=> irq_stat_q[pes_pkg::IRQ_PAGE])
      else $error("page event not held in interrupt status");
   sat_irq_a: assert property (sat_hit |=> irq_stat_q[pes_pkg::IRQ_ERR_SAT])
      else $error("saturation event not flagged");
   lane_keep_a: assert property (wr && idx == pes_pkg::IDX_CTRL2 && !sel_i[0] |=> $stable(ctrl_q[7:0]))
      else $error("disabled byte lane written");
   srst_pulse_a: assert property (soft_rst_o |=> !soft_rst_o)
      else $error("soft reset strobe longer than one cycle");
   link_down_a: assert property (!link_up_i |=> !link_lock_o && !lost)
      else $error("lock held with link down");
   rdata_hold_a: assert property (!rd |=> $stable(dat_o))
      else $error("read data changed without a read");
   ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without a request");

   // Main scenarios
   page_read_c:  cover property (page_q ##1 rd_stat1 ##2 !page_q);
   err_sat_c:    cover property (err_q == pes_pkg::RXERR_MAX && rx_error_i);
   idle_loss_c:  cover property (lost_pulse ##[1:8] idle_seen_i);
   soft_rst_c:   cover property (srst_q ##1 $changed(serdes_an_en_o));
   jabber_irq_c: cover property ($rose(jabber_i) ##1 irq_stat_q[pes_pkg::IRQ_JABBER]);
endmodule
`default_nettype wire

// ===== logic/pes_regs_end.sv
// Companion file of the register bank, holds no code
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== testbench/pes_far_model.sv
// Far-side model: idle symbols and receive error bursts from the link
`timescale 1ns/1ps
`default_nettype none
module pes_far_model (
   // Clock
   input  wire logic        clk_i,
   // Commands from the bench
   input  wire logic        idle_on_i,
   input  wire logic [16:0] err_cnt_i,
   input  wire logic        err_go_i,
   // Toward the block
   output logic             idle_seen_o,
   output logic             rx_error_o
);
   logic [16:0] left_q = 17'h0_0000;
   // Idles flow while enabled and stop dead when silenced
   always_ff @(posedge clk_i) begin
      idle_seen_o <= idle_on_i;
   end
   // One error pulse per cycle until the burst is spent
   always_ff @(posedge clk_i) begin
      if (err_go_i) begin
         left_q <= err_cnt_i;
      end else if (left_q != 17'h0_0000) begin
         left_q <= left_q - 17'h0_0001;
      end
      rx_error_o <= !err_go_i && (left_q != 17'h0_0000);
   end
endmodule
`default_nettype wire

// ===== testbench/pes_regs_bench.sv
// Self-checking bench for the extended status and control register bank
`timescale 1ns/1ps
`default_nettype none
module pes_regs_bench;
   localparam int TO = 16;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat, r;
   logic        ack, an_en_o, lock, srst, irq, idle_seen, rx_err;
   logic [1:0]  speed = 2'h0;
   logic        dup = 1'b0, an_en = 1'b0, an_cpl = 1'b0, page = 1'b0, link = 1'b0;
   logic        xo = 1'b0, jab = 1'b0, txp = 1'b0, rxp = 1'b0, idle_on = 1'b0, err_go = 1'b0;
   logic [3:0]  prev = 4'h0;
   logic [3:0]  sel = 4'h0, sel_v = 4'hF;
   logic [16:0] err_n = 17'h0_0000;
   logic [31:0] exp_q[$];
   int          failures = 0, check_count = 0, cycles = 0, seed = 1, srst_n = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Clock, design and far-side model
   always #2 clk_i = ~clk_i;
   pes_regs #(.IDLE_TIMEOUT_CYC(TO)) u_pes_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .speed_i(speed),
      .full_duplex_i(dup), .tp_an_enable_i(an_en), .tp_an_complete_i(an_cpl), .page_rx_i(page),
      .link_up_i(link), .crossover_i(xo), .pair_reversed_i(prev), .jabber_i(jab), .rx_error_i(rx_err),
      .idle_seen_i(idle_seen), .mac_tx_pause_i(txp), .mac_rx_pause_i(rxp), .serdes_an_en_o(an_en_o),
      .link_lock_o(lock), .soft_rst_o(srst), .irq_o(irq));
   pes_far_model u_pes_far_model (.clk_i(clk_i), .idle_on_i(idle_on), .err_cnt_i(err_n),
      .err_go_i(err_go), .idle_seen_o(idle_seen), .rx_error_o(rx_err));
   ////////////////////////////////////////////////////////////////////////////
   // Compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= sel_v;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Read with its expected data noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   // Expected status word from the inputs now applied
   function automatic logic [31:0] stat(input logic pg, input logic lk);
      return {16'h0000, speed, dup, pg, !an_en || an_cpl, lk, 3'b000, xo, 2'b00, txp, rxp, |prev, jab};
   endfunction
   // Verdict and end of run
   task automatic test_done;
      $display("Checks %0d, failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Monitor: each read answer is matched to the oldest note, soft reset strobes are counted
   always @(posedge clk_i) begin
      if (srst === 1'b1) begin
         srst_n++;
      end
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("CHECK FAILED at %0t: unexpected read answer", $time);
         end else begin
            check(rdat, exp_q.pop_front());
         end
      end
   end
   // Hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 90000) begin
         failures++;
         $display("CHECK FAILED at %0t: timeout", $time);
         test_done();
      end
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h50, 32'h0000_0C68);
      rd(8'h54, 32'h0000_0000);
      check({31'h0, an_en_o}, 32'h0000_0001);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         {speed, dup, an_en, an_cpl, xo, prev, txp, rxp, jab} <= r[12:0];
         repeat (3) @(posedge clk_i);
         rd(8'h44, stat(1'b0, 1'b0));
      end
      page <= 1'b1;
      @(posedge clk_i);
      page <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(8'h44, stat(1'b1, 1'b0));
      rd(8'h44, stat(1'b0, 1'b0));
      $display("test status fields done");
      err_n <= 17'h0_0005;
      err_go <= 1'b1;
      @(posedge clk_i);
      err_go <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(8'h54, 32'h0000_0005);
      rd(8'h54, 32'h0000_0000);
      err_n <= 17'h1_0004;
      err_go <= 1'b1;
      @(posedge clk_i);
      err_go <= 1'b0;
      repeat (65545) @(posedge clk_i);
      check({31'h0, irq}, 32'h0000_0000);
      bus(1'b1, 8'h64, 32'h0000_0008);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, 8'h60, 32'h0000_000F);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h0000_0000);
      rd(8'h54, 32'h0000_FFFF);
      rd(8'h54, 32'h0000_0000);
      $display("test error counter done");
      bus(1'b1, 8'h50, 32'h0000_0C60);
      check({31'h0, an_en_o}, 32'h0000_0001);
      rd(8'h50, 32'h0000_0C60);
      sel_v = 4'h2;
      bus(1'b1, 8'h50, 32'h0000_0CFF);
      sel_v = 4'hF;
      rd(8'h50, 32'h0000_0C60);
      bus(1'b1, 8'h68, 32'h0000_0001);
      repeat (3) @(posedge clk_i);
      check({31'h0, an_en_o}, 32'h0000_0000);
      check(srst_n, 32'h0000_0001);
      rd(8'h7C, 32'h0000_0000);
      $display("test control done");
      link <= 1'b1;
      idle_on <= 1'b1;
      repeat (5) @(posedge clk_i);
      rd(8'h44, stat(1'b0, 1'b1));
      idle_on <= 1'b0;
      repeat (TO + 10) @(posedge clk_i);
      check({31'h0, lock}, 32'h0000_0000);
      rd(8'h50, 32'h0000_8C60);
      rd(8'h44, stat(1'b0, 1'b0));
      rd(8'h60, 32'h0000_0002);
      rd(8'h64, 32'h0000_0008);
      $display("test idle loss done");
      repeat (4) @(posedge clk_i);
      test_done();
   end
endmodule
`default_nettype wire
